// ==== ram_buf_ptrs.sv ====
/*
   Address pointers of a 32-byte buffer shared by an i2c master and firmware,
   together with the buffer itself and the firmware register port.
   Assumes a bus-side byte engine that decodes start, stop, own address and
   data bytes and reports each as a one-cycle event, synchronous to core_clk_i.
*/
// The plain strobed port was chosen for this implementation.
// Behaviour
// - first write data byte loads bus base pointer
// - later write bytes stored, address advancing
// - reads start at bus base, then increment
// - bus base changes only at write start
// - bus base read-only, resets zero, read start
// - bus current loaded with bus base together
// - bus current increments after each data byte
// - bus current addresses every bus byte
// - every start reloads bus current from base
// - firmware base read-write, reset zero, firmware-set
// - firmware base write also loads firmware current
// - first buffer access after base uses base
// - firmware current increments per buffer access
// - firmware current read-only, reset zero, addresses
// - buffered mode: ram, no stall, auto ack
// - buffer register reads/writes at firmware current
`include "ram_buf_cfg.svh"

module ram_buf_ptrs #(
   parameter int DEPTH = `BUF_DEPTH,
   parameter int PW = `PTR_W,
   parameter int DW = `BYTE_W
) (
   input wire logic core_clk_i,                    // system clock, 50 MHz
   input wire logic rst_i,                         // async reset, active high
   input wire logic [7:0] addr_i,                  // register address
   input wire logic [7:0] wdata_i,                 // register write data
   input wire logic wr_i,                          // register write strobe
   input wire logic rd_i,                          // register read strobe
   output logic [7:0] rdata_o,                     // read data, cycle after rd_i
   input wire ram_buf_pkg::bus_event_type bus_evt_i, // bus-side byte events
   output ram_buf_pkg::bus_reply_type bus_reply_o, // ack and byte to send
   output logic busy_o                             // bus transaction in progress
);
   import ram_buf_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // declarations

   logic mode_en;
   logic [PW-1:0] bus_base;
   logic [PW-1:0] bus_cur;
   logic [PW-1:0] fw_base;
   logic [PW-1:0] fw_cur;
   bus_phase_type phase;
   bus_phase_type next_phase;

   logic bus_cur_load;
   logic [PW-1:0] bus_cur_load_val;
   logic bus_cur_inc;
   logic bus_base_load;
   logic bus_mem_we;

   logic fw_cur_load;
   logic fw_cur_inc;
   logic fw_mem_we;
   logic buf_access;

   logic [DW-1:0] bus_mem_rd;
   logic [DW-1:0] fw_mem_rd;
   logic [7:0] next_rdata;

   ////////////////////////////////////////////////////////////////////////
   // mode register

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mode_en <= `MODE_RST;
      end
      else if (wr_i && addr_i == `MODE_CFG_OFF)
      begin
         mode_en <= wdata_i[`MODE_EN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus-side transaction phase

   always_comb
   begin
      next_phase = phase;
      case (phase)
         PH_IDLE:
         begin
            if (bus_evt_i.start)
            begin
               next_phase = PH_ADDR;
            end
         end
         PH_ADDR:
         begin
            if (bus_evt_i.addr_done)
            begin
               // a write must open with the base byte
               next_phase = bus_evt_i.addr_read ? PH_READ : PH_BASE;
            end
         end
         PH_BASE, PH_WRITE, PH_READ:
         begin
            if (bus_evt_i.start)
            begin
               next_phase = PH_ADDR;
            end
            else if (phase == PH_BASE && bus_evt_i.byte_done)
            begin
               next_phase = PH_WRITE;
            end
         end
         default:
         begin
            next_phase = PH_IDLE;
         end
      endcase
      // stop ends any transaction; a foreign address stays in PH_ADDR until stop
      if (bus_evt_i.stop || !mode_en)
      begin
         next_phase = PH_IDLE;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         phase <= PH_IDLE;
      end
      else
      begin
         phase <= next_phase;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus-side pointer control

   always_comb
   begin
      bus_base_load = 1'b0;
      bus_cur_load = 1'b0;
      bus_cur_load_val = bus_base;
      bus_cur_inc = 1'b0;
      bus_mem_we = 1'b0;
      if (mode_en)
      begin
         if (bus_evt_i.start)
         begin
            bus_cur_load = 1'b1;
            bus_cur_load_val = bus_base;
         end
         else if (bus_evt_i.byte_done)
         begin
            case (phase)
               PH_BASE:
               begin
                  // only the opening byte of a write moves the base
                  bus_base_load = 1'b1;
                  bus_cur_load = 1'b1;
                  bus_cur_load_val = bus_evt_i.byte_val[`PTR_MSB:`PTR_LSB];
               end
               PH_WRITE:
               begin
                  bus_mem_we = 1'b1;
                  bus_cur_inc = 1'b1;
               end
               PH_READ:
               begin
                  bus_cur_inc = 1'b1;
               end
               default:
               begin
                  bus_cur_inc = 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         bus_base <= `PTR_RST;
      end
      else if (bus_base_load)
      begin
         bus_base <= bus_evt_i.byte_val[`PTR_MSB:`PTR_LSB];
      end
   end

   ptr_counter #(
      .WIDTH(PW)
   ) bus_cur_ctr (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .load_i(bus_cur_load),
      .load_val_i(bus_cur_load_val),
      .inc_i(bus_cur_inc),
      .ptr_o(bus_cur)
   );

   ////////////////////////////////////////////////////////////////////////
   // bus-side answer

   // byte to send tracks the location at the bus current pointer;
   // a read restarting at base is ready two cycles after the start event
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         bus_reply_o.tx_byte <= `BYTE_RST;
      end
      else
      begin
         bus_reply_o.tx_byte <= bus_mem_rd;
      end
   end

   // receive bytes are acknowledged whenever mode_en is set, so the bus never waits
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         bus_reply_o.ack <= 1'b0;
      end
      else
      begin
         bus_reply_o.ack <= mode_en;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         busy_o <= 1'b0;
      end
      else
      begin
         busy_o <= next_phase != PH_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // firmware-side pointers

   assign buf_access = (wr_i || rd_i) && addr_i == `DATA_BUF_OFF;
   assign fw_cur_load = wr_i && addr_i == `FW_BASE_OFF;
   assign fw_cur_inc = buf_access;
   assign fw_mem_we = wr_i && addr_i == `DATA_BUF_OFF;

   // upper bits are expected zero and are simply not stored
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         fw_base <= `PTR_RST;
      end
      else if (fw_cur_load)
      begin
         fw_base <= wdata_i[`PTR_MSB:`PTR_LSB];
      end
   end

   // a base write loads current too, so the next access hits base
   ptr_counter #(
      .WIDTH(PW)
   ) fw_cur_ctr (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .load_i(fw_cur_load),
      .load_val_i(wdata_i[`PTR_MSB:`PTR_LSB]),
      .inc_i(fw_cur_inc),
      .ptr_o(fw_cur)
   );

   ////////////////////////////////////////////////////////////////////////
   // shared buffer

   // the bus side wins a same-location clash: it cannot be stalled
   dual_flop_ram #(
      .DEPTH(DEPTH),
      .AW(PW),
      .DW(DW)
   ) buf_mem (
      .core_clk_i(core_clk_i),
      .a_we_i(bus_mem_we),
      .a_addr_i(bus_cur),
      .a_wd_i(bus_evt_i.byte_val),
      .a_rd_o(bus_mem_rd),
      .b_we_i(fw_mem_we),
      .b_addr_i(fw_cur),
      .b_wd_i(wdata_i),
      .b_rd_o(fw_mem_rd)
   );

   ////////////////////////////////////////////////////////////////////////
   // register read port

   always_comb
   begin
      next_rdata = 8'h00;
      case (addr_i)
         `MODE_CFG_OFF:
         begin
            next_rdata[`MODE_EN_BIT] = mode_en;
         end
         `BUS_BASE_OFF:
         begin
            next_rdata[`PTR_MSB:`PTR_LSB] = bus_base;
         end
         `BUS_CUR_OFF:
         begin
            next_rdata[`PTR_MSB:`PTR_LSB] = bus_cur;
         end
         `FW_BASE_OFF:
         begin
            next_rdata[`PTR_MSB:`PTR_LSB] = fw_base;
         end
         `FW_CUR_OFF:
         begin
            next_rdata[`PTR_MSB:`PTR_LSB] = fw_cur;
         end
         `DATA_BUF_OFF:
         begin
            next_rdata = fw_mem_rd;
         end
         default:
         begin
            next_rdata = 8'h00;
         end
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rdata_o <= 8'h00;
      end
      else if (rd_i)
      begin
         rdata_o <= next_rdata;
      end
      else
      begin
         rdata_o <= 8'h00;
      end
   end

endmodule

// ==== ram_buf_cfg.svh ====
/*
   Register offsets, field positions and reset values of the buffered
   pointer block.
   Assumes it is included by bare name wherever these constants are used.
*/
`ifndef RAM_BUF_CFG_SVH
`define RAM_BUF_CFG_SVH

// register offsets on the firmware port
`define MODE_CFG_OFF 8'hc7
`define BUS_BASE_OFF 8'hcb
`define BUS_CUR_OFF 8'hcc
`define FW_BASE_OFF 8'hcd
`define FW_CUR_OFF 8'hce
`define DATA_BUF_OFF 8'hcf

// field layout
`define PTR_MSB 4
`define PTR_LSB 0
`define MODE_EN_BIT 0

// reset values
`define PTR_RST 5'h00
`define BYTE_RST 8'h00
`define MODE_RST 1'b0

// storage shape
`define BUF_DEPTH 32
`define PTR_W 5
`define BYTE_W 8

`endif

// ==== ram_buf_pkg.sv ====
/*
   Types shared by the buffered pointer block and its leaf modules.
   Assumes ram_buf_cfg.svh is compiled with it.
*/
package ram_buf_pkg;

   // one-cycle events from the bus-side byte engine
   typedef struct packed {
      logic start;        // start or repeated start seen
      logic stop;         // stop seen
      logic addr_done;    // own slave address taken
      logic addr_read;    // direction bit of that address, 1 = master read
      logic byte_done;    // data byte completed
      logic [7:0] byte_val; // received byte, valid with byte_done on writes
   } bus_event_type;

   // answer to the bus-side byte engine
   typedef struct packed {
      logic ack;          // acknowledge received bytes
      logic [7:0] tx_byte; // byte to send on master reads
   } bus_reply_type;

   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_ADDR = 3'b001,
      PH_BASE = 3'b010,
      PH_WRITE = 3'b011,
      PH_READ = 3'b100
   } bus_phase_type;

endpackage

// ==== ptr_counter.sv ====
/*
   Wrapping pointer register: load wins over increment.
   Assumes a single clock and an asynchronous active-high reset.
*/
module ptr_counter #(
   parameter int WIDTH = 5
) (
   input wire logic core_clk_i,          // system clock
   input wire logic rst_i,               // async reset, active high
   input wire logic load_i,              // load pulse
   input wire logic [WIDTH-1:0] load_val_i, // value to load
   input wire logic inc_i,               // increment pulse
   output logic [WIDTH-1:0] ptr_o        // pointer value
);

   // natural overflow gives the wrap from top to zero
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ptr_o <= '0;
      end
      else if (load_i)
      begin
         ptr_o <= load_val_i;
      end
      else if (inc_i)
      begin
         ptr_o <= ptr_o + WIDTH'(1);
      end
   end

endmodule

// ==== dual_flop_ram.sv ====
/*
   Two-port flip-flop buffer: two write ports, two read ports.
   Assumes a single clock; port a wins when both write one location.
*/
module dual_flop_ram #(
   parameter int DEPTH = 32,
   parameter int AW = 5,
   parameter int DW = 8
) (
   input wire logic core_clk_i,        // system clock
   input wire logic a_we_i,            // port a write
   input wire logic [AW-1:0] a_addr_i, // port a address
   input wire logic [DW-1:0] a_wd_i,   // port a write data
   output logic [DW-1:0] a_rd_o,       // port a read data
   input wire logic b_we_i,            // port b write
   input wire logic [AW-1:0] b_addr_i, // port b address
   input wire logic [DW-1:0] b_wd_i,   // port b write data
   output logic [DW-1:0] b_rd_o        // port b read data
);

   logic [DW-1:0] mem [DEPTH];

   // contents are undefined until written, as for a real ram
   always_ff @(posedge core_clk_i)
   begin
      if (b_we_i)
      begin
         mem[b_addr_i] <= b_wd_i;
      end
      if (a_we_i)
      begin
         mem[a_addr_i] <= a_wd_i;
      end
   end

   assign a_rd_o = mem[a_addr_i];
   assign b_rd_o = mem[b_addr_i];

endmodule

// ==== ram_buf_ptrs_sva.sv ====
/*
   Port checker for the buffered pointer block.
   Assumes one clock, an async active-high reset and the register timing of the block.
*/
`include "ram_buf_cfg.svh"
module ram_buf_ptrs_sva #(
   parameter int DEPTH = 32,
   parameter int PW = 5,
   parameter int DW = 8
) (
   input wire logic core_clk_i, // system clock
   input wire logic rst_i, // async reset
   input wire logic [7:0] addr_i, // register address
   input wire logic [7:0] wdata_i, // write data
   input wire logic wr_i, // write strobe
   input wire logic rd_i, // read strobe
   input wire logic [7:0] rdata_o, // read data
   input wire ram_buf_pkg::bus_event_type bus_evt_i, // bus events
   input wire ram_buf_pkg::bus_reply_type bus_reply_o, // ack and tx byte
   input wire logic busy_o // transaction busy
);
   import ram_buf_pkg::*;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   logic mode_wr;
   assign mode_wr = wr_i && addr_i == `MODE_CFG_OFF && wdata_i[`MODE_EN_BIT];
   ////////////////////////////////////////////////////////////////////////////
   AST_RDATA_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data seen without a read");
   AST_PTR_UPPER: assert property (rd_i && addr_i inside {8'hcb, 8'hcc, 8'hcd, 8'hce} |=> rdata_o[7:5] == 3'b000)
      else $error("pointer upper bits not zero");
   AST_FW_BASE_RB: assert property (wr_i && addr_i == `FW_BASE_OFF ##1 rd_i && addr_i == `FW_BASE_OFF
      |=> rdata_o == {3'b000, $past(wdata_i[4:0], 2)})
      else $error("firmware base readback wrong");
   AST_FW_CUR_LOAD: assert property (wr_i && addr_i == `FW_BASE_OFF ##1 rd_i && addr_i == `FW_CUR_OFF
      |=> rdata_o == {3'b000, $past(wdata_i[4:0], 2)})
      else $error("firmware current not loaded with base");
   AST_CUR_HOLD: assert property (rd_i && addr_i == `FW_CUR_OFF ##1 rd_i && addr_i == `FW_CUR_OFF
      |=> rdata_o == $past(rdata_o))
      else $error("firmware current moved without buffer access");
   AST_BUS_BASE: assert property (bus_evt_i.start && bus_reply_o.ack ##1 bus_evt_i.addr_done && !bus_evt_i.addr_read
      ##1 bus_evt_i.byte_done ##1 rd_i && addr_i == `BUS_BASE_OFF
      |=> rdata_o == {3'b000, $past(bus_evt_i.byte_val[4:0], 2)})
      else $error("bus base not taken from first write byte");
   AST_ACK_MODE: assert property ($rose(bus_reply_o.ack) |-> $past(mode_wr) || $past(mode_wr, 2))
      else $error("ack rose without mode enable");
   AST_BUSY_START: assert property (bus_evt_i.start && bus_reply_o.ack |-> ##[1:2] busy_o)
      else $error("start did not open a transaction");
   AST_BUSY_STOP: assert property (bus_evt_i.stop && bus_reply_o.ack |-> ##[1:2] !busy_o)
      else $error("stop did not close the transaction");
   ////////////////////////////////////////////////////////////////////////////
   COV_BYTE: cover property (bus_evt_i.byte_done && busy_o);
   COV_BUF_RD: cover property (rd_i && addr_i == `DATA_BUF_OFF);
   COV_END: cover property ($fell(busy_o));
endmodule
bind ram_buf_ptrs ram_buf_ptrs_sva #(.DEPTH(DEPTH), .PW(PW), .DW(DW)) u_sva (.core_clk_i(core_clk_i),
   .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .bus_evt_i(bus_evt_i), .bus_reply_o(bus_reply_o), .busy_o(busy_o));

// ==== bus_master_model.sv ====
/*
   Model of the bus-side byte engine reporting an external master's events.
   Assumes one calling process; every change lands right after a rising edge.
*/
module bus_master_model (
   input wire logic core_clk_i, // system clock
   output ram_buf_pkg::bus_event_type evt_o // event pulses
);
   import ram_buf_pkg::*;
   initial evt_o = '0;
   // caller always follows an event with idle or another event
   // byte value is noise unless a byte completes, so it must be ignored
   task automatic send(input logic [4:0] kind, input logic [7:0] val);
      @(posedge core_clk_i);
      evt_o <= {kind, kind[0] ? val : 8'($urandom)};
   endtask
   // released byte shows the inverse so stale data never looks valid
   task automatic idle(input int n);
      repeat (n)
      begin
         @(posedge core_clk_i);
         evt_o <= {5'b00000, ~evt_o.byte_val};
      end
   endtask
endmodule

// ==== ram_buf_ptrs_tb.sv ====
/*
   Self-checking bench for the buffered pointer block.
   Assumes the event model on the bus side and this bench as firmware.
*/
`include "ram_buf_cfg.svh"
module ram_buf_ptrs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ram_buf_pkg::*;
   logic core_clk_i = 0, rst_i, wr_i, rd_i, rd_seen = 0, busy_o;
   logic [7:0] addr_i, wdata_i, rdata_o, v;
   bus_event_type bus_evt_i;
   bus_reply_type bus_reply_o;
   logic [7:0] mem [32];
   logic [4:0] fc = 0, bb = 0, bc = 0;
   logic [7:0] exp_q [$];
   int bad_count = 0, checks_done = 0;
   always #10 core_clk_i = ~core_clk_i;
   ram_buf_ptrs DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .bus_evt_i(bus_evt_i), .bus_reply_o(bus_reply_o), .busy_o(busy_o));
   bus_master_model bm (.core_clk_i(core_clk_i), .evt_o(bus_evt_i));
   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // port levels sampled mid-cycle
   task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
      chk_rd(got, exp);
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      wr_i <= w;
      rd_i <= !w;
      addr_i <= a;
      wdata_i <= d;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      acc(0, a, ~e);
   endtask
   task automatic quiet;
      @(posedge core_clk_i);
      wr_i <= 0;
      rd_i <= 0;
   endtask
   task automatic fw_wr(input logic [7:0] d);
      mem[fc] = d;
      fc++;
      acc(1, `DATA_BUF_OFF, d);
   endtask
   task automatic tx_is(input logic [4:0] p);
      @(negedge core_clk_i);
      chk_out(bus_reply_o.tx_byte, mem[p]);
   endtask
   task automatic wait_busy(input logic b);
      int n;
      n = 0;
      while (busy_o !== b && n < 4)
      begin
         @(negedge core_clk_i);
         n++;
      end
      chk_out({7'h00, busy_o}, {7'h00, b});
      if (busy_o !== b)
         give_verdict;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk_i) rd_seen <= rd_i;
   always @(negedge core_clk_i)
      if (rd_seen)
         chk_rd(rdata_o, exp_q.pop_front());
   initial
   begin
      void'($urandom(35));
      rst_i = 1'b1;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 8'($urandom);
      wdata_i = 8'($urandom);
      repeat (5) @(posedge core_clk_i);
      rst_i <= 0;
      rd(`MODE_CFG_OFF, 8'h00);
      rd(`BUS_BASE_OFF, 8'h00);
      rd(`BUS_CUR_OFF, 8'h00);
      rd(`FW_BASE_OFF, 8'h00);
      rd(`FW_CUR_OFF, 8'h00);
      rd(8'h10, 8'h00);
      acc(1, `MODE_CFG_OFF, 8'h01);
      quiet;
      // mode lands one edge after the write, ack one edge later still
      repeat (2) @(negedge core_clk_i);
      chk_out({7'h00, bus_reply_o.ack}, 8'h01);
      v = 8'($urandom);
      acc(1, `FW_BASE_OFF, {3'b000, v[4:0]});
      rd(`FW_CUR_OFF, {3'b000, v[4:0]});
      acc(1, `FW_BASE_OFF, 8'h1e);
      rd(`FW_BASE_OFF, 8'h1e);
      fc = 5'h1e;
      for (int i = 0; i < 4; i++) fw_wr(8'($urandom));
      acc(1, `BUS_BASE_OFF, 8'h07);
      acc(1, `BUS_CUR_OFF, 8'h07);
      acc(1, `FW_CUR_OFF, 8'h07);
      rd(`FW_CUR_OFF, 8'h02);
      rd(`FW_CUR_OFF, 8'h02);
      rd(`BUS_BASE_OFF, 8'h00);
      quiet;
      v = 8'($urandom);
      bm.send(5'b10000, 8'h00);
      bm.send(5'b00100, 8'h00);
      bm.send(5'b00001, {v[7:5], 5'h1f});
      bb = 5'h1f;
      bc = bb;
      fork
         bm.idle(1);
         rd(`BUS_BASE_OFF, 8'h1f);
      join
      quiet;
      for (int i = 0; i < 3; i++)
      begin
         mem[bc] = 8'($urandom);
         bm.send(5'b00001, mem[bc]);
         bc++;
         bm.idle(i + 1);
      end
      bm.send(5'b01000, 8'h00);
      bm.idle(2);
      wait_busy(0);
      rd(`BUS_CUR_OFF, 8'h02);
      rd(`BUS_BASE_OFF, 8'h1f);
      acc(1, `FW_BASE_OFF, 8'h1f);
      fc = 5'h1f;
      for (int i = 0; i < 3; i++)
      begin
         rd(`DATA_BUF_OFF, mem[fc]);
         fc++;
      end
      quiet;
      bm.send(5'b10000, 8'h00);
      bm.idle(1);
      wait_busy(1);
      bm.send(5'b00110, 8'h00);
      bm.idle(2);
      bc = bb;
      tx_is(bc);
      for (int i = 0; i < 2; i++)
      begin
         bm.send(5'b00001, 8'h5a);
         bm.idle(2);
         bc++;
         tx_is(bc);
      end
      bm.send(5'b10000, 8'h00);
      bm.idle(2);
      tx_is(bb);
      bm.send(5'b01000, 8'h00);
      bm.idle(2);
      rd(`BUS_BASE_OFF, 8'h1f);
      rd(`BUS_CUR_OFF, 8'h1f);
      acc(1, `MODE_CFG_OFF, 8'h00);
      quiet;
      bm.send(5'b10000, 8'h00);
      bm.send(5'b00100, 8'h00);
      bm.send(5'b00001, 8'h05);
      bm.idle(2);
      wait_busy(0);
      rd(`BUS_BASE_OFF, 8'h1f);
      quiet;
      repeat (3) @(posedge core_clk_i);
      give_verdict;
   end
endmodule
